/* File: src/i2css_top.sv */
/*
 i2c slave state engine with apb registers: slave receive and transmit end states,
 start after lost arbitration, start request after end states
 assumes open-drain lines resolved outside; pclk far above the bus bit rate
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2css_cfg.svh"

module i2css_top #(
	parameter int HALF_CYC = `I2CSS_HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire i2css_pkg::i2css_line_type line_in,
	output i2css_pkg::i2css_line_type line_out,
	output i2css_pkg::i2css_line_type line_oe
);

	// the half-period timer is eight bits wide
	if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_half_check
		$error("HALF_CYC out of range");
	end

	i2css_pkg::i2css_line_type line_s;
	i2css_pkg::i2css_line_type line_q;
	i2css_pkg::i2css_state_type state;
	logic [3:0] cnt;
	logic [7:0] shreg;
	logic [7:0] shift_data_reg;
	logic [7:0] own_address_reg;
	logic [7:0] code_reg;
	logic [7:0] timer;
	logic ack_enable_flag;
	logic start_request_flag;
	logic stop_request_flag;
	logic si_flag;
	logic si_set;
	logic arb_set;
	logic start_clr;
	logic stop_clr;
	logic ack_this;
	logic is_gc;
	logic last_byte;
	logic arb_lost;
	logic ack_bit;
	logic mrw;
	logic phase;
	logic stretch;
	logic bus_busy;
	logic drive_sda;
	logic drive_scl;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;

	i2css_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.line_in(line_in),
		.line_out(line_s)
	);

	// line events
	wire scl_rise = line_s.scl & ~line_q.scl;
	wire scl_fall = ~line_s.scl & line_q.scl;
	wire start_det = line_s.scl & line_q.scl & line_q.sda & ~line_s.sda;
	wire stop_det = line_s.scl & line_q.scl & ~line_q.sda & line_s.sda;
	wire half_done = (timer == 8'(HALF_CYC - 1));

	// address decode
	wire own_hit = ack_enable_flag & (shreg[7:1] == own_address_reg[7:1]);
	wire gc_hit = ack_enable_flag & own_address_reg[0] & (shreg[7:1] == 7'h00);
	wire hold_exit = (state == i2css_pkg::ST_HOLD) & ~si_flag & ~si_set;
	wire end_code = (code_reg == `I2CSS_ST_RX_NACK) | (code_reg == `I2CSS_ST_GRX_NACK) |
		(code_reg == `I2CSS_ST_STOP) | (code_reg == `I2CSS_ST_TX_NACK) |
		(code_reg == `I2CSS_ST_TX_LAST) | (code_reg == `I2CSS_ST_ARB);
	wire mst_code = (code_reg == `I2CSS_ST_MW_ACK) | (code_reg == `I2CSS_ST_MW_NACK) |
		(code_reg == `I2CSS_ST_MR_ACK) | (code_reg == `I2CSS_ST_MR_NACK);
	wire tx_code = (code_reg == `I2CSS_ST_SR) | (code_reg == `I2CSS_ST_SR_ARB) |
		(code_reg == `I2CSS_ST_TX_ACK);
	wire addressed = (state == i2css_pkg::ST_AACK) | (state == i2css_pkg::ST_RX) |
		(state == i2css_pkg::ST_RACK) | (state == i2css_pkg::ST_TX) |
		(state == i2css_pkg::ST_TACK);

	// apb decode
	wire setup = psel & ~penable;
	wire access = psel & penable & pready;
	wire sel_ctl = (paddr == `I2CSS_OFS_CONTROL);
	wire sel_stat = (paddr == `I2CSS_OFS_STATUS);
	wire sel_data = (paddr == `I2CSS_OFS_DATA);
	wire sel_adr = (paddr == `I2CSS_OFS_OWNADR);
	wire sel_ist = (paddr == `I2CSS_OFS_IRQ_STAT);
	wire sel_imk = (paddr == `I2CSS_OFS_IRQ_MASK);
	wire hit = sel_ctl | sel_stat | sel_data | sel_adr | sel_ist | sel_imk;
	wire wr_ctl = access & pwrite & sel_ctl;
	wire wr_data = access & pwrite & sel_data;
	wire [7:0] status_view = si_flag ? code_reg : `I2CSS_ST_IDLE;
	wire [31:0] ctl_word = {26'h000_0000, start_request_flag, stop_request_flag, si_flag,
		ack_enable_flag, 2'h0};
	wire [31:0] rd_data = sel_ctl ? ctl_word :
		sel_stat ? {24'h00_0000, status_view} :
		sel_data ? {24'h00_0000, shift_data_reg} :
		sel_adr ? {24'h00_0000, own_address_reg} :
		sel_ist ? {30'h0000_0000, irq_status} :
		sel_imk ? {30'h0000_0000, irq_mask} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			prdata <= setup ? rd_data : 32'h0000_0000;
			pslverr <= setup & ~hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_enable_flag <= 1'b0;
			start_request_flag <= 1'b0;
			stop_request_flag <= 1'b0;
			si_flag <= 1'b0;
			own_address_reg <= `I2CSS_RST_OWNADR;
			irq_mask <= `I2CSS_RST_MASK;
			irq_status <= 2'h0;
			irq <= 1'b0;
		end else begin
			if (wr_ctl) begin
				ack_enable_flag <= pwdata[`I2CSS_CTL_AA];
			end
			if (start_clr) begin
				start_request_flag <= 1'b0;
			end else if (wr_ctl) begin
				start_request_flag <= pwdata[`I2CSS_CTL_STA];
			end
			if (stop_clr) begin
				stop_request_flag <= 1'b0;
			end else if (wr_ctl) begin
				stop_request_flag <= pwdata[`I2CSS_CTL_STO];
			end
			// set wins over the one-to-clear write
			si_flag <= si_set | (si_flag & ~(wr_ctl & pwdata[`I2CSS_CTL_SI]));
			if (access & pwrite & sel_adr) begin
				own_address_reg <= pwdata[7:0];
			end
			if (access & pwrite & sel_imk) begin
				irq_mask <= pwdata[1:0];
			end
			irq_status[`I2CSS_IRQ_SI] <= si_set | (irq_status[`I2CSS_IRQ_SI] &
				~(access & pwrite & sel_ist & pwdata[`I2CSS_IRQ_SI]));
			irq_status[`I2CSS_IRQ_ARB] <= arb_set | (irq_status[`I2CSS_IRQ_ARB] &
				~(access & pwrite & sel_ist & pwdata[`I2CSS_IRQ_ARB]));
			irq <= |(irq_status & irq_mask);
		end
	end

	// bus busy between start and stop; output pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_q <= 2'h3;
			bus_busy <= 1'b0;
			line_out <= 2'h0;
			line_oe <= 2'h0;
		end else begin
			line_q <= line_s;
			bus_busy <= start_det | (bus_busy & ~stop_det);
			line_out <= 2'h0;
			line_oe <= {drive_scl, drive_sda};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= i2css_pkg::ST_IDLE;
			cnt <= 4'h0;
			shreg <= 8'h00;
			shift_data_reg <= 8'h00;
			code_reg <= `I2CSS_ST_IDLE;
			timer <= 8'h00;
			si_set <= 1'b0;
			arb_set <= 1'b0;
			start_clr <= 1'b0;
			stop_clr <= 1'b0;
			ack_this <= 1'b0;
			is_gc <= 1'b0;
			last_byte <= 1'b0;
			arb_lost <= 1'b0;
			ack_bit <= 1'b0;
			mrw <= 1'b0;
			phase <= 1'b0;
			stretch <= 1'b0;
			drive_sda <= 1'b0;
			drive_scl <= 1'b0;
		end else begin
			si_set <= 1'b0;
			arb_set <= 1'b0;
			start_clr <= 1'b0;
			stop_clr <= 1'b0;
			timer <= half_done ? 8'h00 : timer + 8'h01;
			if (wr_data) begin
				shift_data_reg <= pwdata[7:0];
			end
			if (addressed & (stop_det | start_det)) begin
				code_reg <= `I2CSS_ST_STOP;
				si_set <= 1'b1;
				stretch <= 1'b0;
				drive_sda <= 1'b0;
				drive_scl <= 1'b0;
				state <= i2css_pkg::ST_HOLD;
			end else begin
				unique case (state)
				i2css_pkg::ST_IDLE: begin
					drive_sda <= 1'b0;
					drive_scl <= 1'b0;
					arb_lost <= 1'b0;
					cnt <= 4'h0;
					if (start_det) begin
						state <= i2css_pkg::ST_ADDR;
					end
				end
				i2css_pkg::ST_ADDR: begin
					if (stop_det) begin
						state <= i2css_pkg::ST_IDLE;
					end else if (start_det) begin
						cnt <= 4'h0;
					end else if (cnt == 4'h8) begin
						cnt <= 4'h0;
						is_gc <= gc_hit & ~own_hit;
						if (own_hit & shreg[0]) begin
							code_reg <= arb_lost ? `I2CSS_ST_SR_ARB : `I2CSS_ST_SR;
							state <= i2css_pkg::ST_AACK;
						end else if (own_hit) begin
							code_reg <= arb_lost ? `I2CSS_ST_SW_ARB : `I2CSS_ST_SW;
							state <= i2css_pkg::ST_AACK;
						end else if (gc_hit) begin
							code_reg <= arb_lost ? `I2CSS_ST_GC_ARB : `I2CSS_ST_GC;
							state <= i2css_pkg::ST_AACK;
						end else if (arb_lost) begin
							code_reg <= `I2CSS_ST_ARB;
							si_set <= 1'b1;
							stretch <= 1'b0;
							state <= i2css_pkg::ST_HOLD;
						end else begin
							state <= i2css_pkg::ST_IDLE;
						end
					end else if (scl_rise) begin
						shreg <= {shreg[6:0], line_s.sda};
						cnt <= cnt + 4'h1;
					end
				end
				i2css_pkg::ST_AACK: begin
					if (scl_fall & (cnt == 4'h0)) begin
						drive_sda <= 1'b1;
						cnt <= 4'h1;
					end else if (scl_fall) begin
						drive_sda <= 1'b0;
						drive_scl <= 1'b1;
						stretch <= 1'b1;
						si_set <= 1'b1;
						state <= i2css_pkg::ST_HOLD;
					end
				end
				i2css_pkg::ST_RX: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], line_s.sda};
						cnt <= cnt + 4'h1;
					end else if (scl_fall & (cnt == 4'h8)) begin
						drive_sda <= ack_this;
						state <= i2css_pkg::ST_RACK;
					end
				end
				i2css_pkg::ST_RACK: begin
					if (scl_fall) begin
						drive_sda <= 1'b0;
						drive_scl <= 1'b1;
						stretch <= 1'b1;
						shift_data_reg <= shreg;
						si_set <= 1'b1;
						if (is_gc) begin
							code_reg <= ack_this ? `I2CSS_ST_GRX_ACK : `I2CSS_ST_GRX_NACK;
						end else begin
							code_reg <= ack_this ? `I2CSS_ST_RX_ACK : `I2CSS_ST_RX_NACK;
						end
						state <= i2css_pkg::ST_HOLD;
					end
				end
				i2css_pkg::ST_TX: begin
					if (scl_fall & (cnt == 4'h7)) begin
						drive_sda <= 1'b0;
						state <= i2css_pkg::ST_TACK;
					end else if (scl_fall) begin
						shreg <= {shreg[6:0], 1'b0};
						drive_sda <= ~shreg[6];
						cnt <= cnt + 4'h1;
					end
				end
				i2css_pkg::ST_TACK: begin
					if (scl_rise) begin
						ack_bit <= ~line_s.sda;
					end else if (scl_fall) begin
						if (!ack_bit) begin
							code_reg <= `I2CSS_ST_TX_NACK;
						end else begin
							code_reg <= last_byte ? `I2CSS_ST_TX_LAST : `I2CSS_ST_TX_ACK;
						end
						drive_scl <= 1'b1;
						stretch <= 1'b1;
						si_set <= 1'b1;
						state <= i2css_pkg::ST_HOLD;
					end
				end
				i2css_pkg::ST_HOLD: begin
					drive_scl <= stretch;
					if (hold_exit) begin
						cnt <= 4'h0;
						timer <= 8'h00;
						phase <= 1'b0;
						stretch <= 1'b0;
						if (stop_request_flag & ~mst_code) begin
							stop_clr <= 1'b1;
							drive_scl <= 1'b0;
							drive_sda <= 1'b0;
							state <= i2css_pkg::ST_IDLE;
						end else if (end_code) begin
							drive_scl <= 1'b0;
							drive_sda <= 1'b0;
							state <= start_request_flag ? i2css_pkg::ST_WFREE :
								i2css_pkg::ST_IDLE;
						end else if (code_reg == `I2CSS_ST_MSTART) begin
							shreg <= shift_data_reg;
							mrw <= shift_data_reg[0];
							state <= i2css_pkg::ST_MBIT;
						end else if (mst_code) begin
							stop_clr <= stop_request_flag;
							drive_sda <= stop_request_flag;
							drive_scl <= stop_request_flag;
							state <= stop_request_flag ? i2css_pkg::ST_MSTOP : i2css_pkg::ST_IDLE;
						end else if (tx_code) begin
							shreg <= shift_data_reg;
							drive_sda <= ~shift_data_reg[7];
							last_byte <= ~ack_enable_flag;
							drive_scl <= 1'b0;
							state <= i2css_pkg::ST_TX;
						end else begin
							ack_this <= ack_enable_flag;
							drive_scl <= 1'b0;
							state <= i2css_pkg::ST_RX;
						end
					end
				end
				i2css_pkg::ST_WFREE: begin
					if (bus_busy) begin
						timer <= 8'h00;
					end else if (half_done) begin
						drive_sda <= 1'b1;
						state <= i2css_pkg::ST_MSTART;
					end
				end
				i2css_pkg::ST_MSTART: begin
					if (half_done) begin
						drive_scl <= 1'b1;
						stretch <= 1'b1;
						start_clr <= 1'b1;
						code_reg <= `I2CSS_ST_MSTART;
						si_set <= 1'b1;
						state <= i2css_pkg::ST_HOLD;
					end
				end
				i2css_pkg::ST_MBIT: begin
					if (!phase) begin
						drive_sda <= (cnt == 4'h8) ? 1'b0 : ~shreg[7];
						if (half_done) begin
							drive_scl <= 1'b0;
							phase <= 1'b1;
						end
					end else if (!line_s.scl) begin
						timer <= 8'h00;
					end else if (half_done) begin
						phase <= 1'b0;
						if ((cnt != 4'h8) & ~drive_sda & ~line_s.sda) begin
							drive_sda <= 1'b0;
							arb_lost <= 1'b1;
							arb_set <= 1'b1;
							// keep the bus bits so the slave decode sees the whole address
							shreg <= {shreg[6:0], line_s.sda};
							cnt <= cnt + 4'h1;
							state <= i2css_pkg::ST_ADDR;
						end else if (cnt == 4'h8) begin
							drive_scl <= 1'b1;
							stretch <= 1'b1;
							si_set <= 1'b1;
							if (mrw) begin
								code_reg <= ~line_s.sda ? `I2CSS_ST_MR_ACK : `I2CSS_ST_MR_NACK;
							end else begin
								code_reg <= ~line_s.sda ? `I2CSS_ST_MW_ACK : `I2CSS_ST_MW_NACK;
							end
							state <= i2css_pkg::ST_HOLD;
						end else begin
							drive_scl <= 1'b1;
							shreg <= {shreg[6:0], line_s.sda};
							cnt <= cnt + 4'h1;
						end
					end
				end
				i2css_pkg::ST_MSTOP: begin
					if (!phase) begin
						if (half_done) begin
							drive_scl <= 1'b0;
							phase <= 1'b1;
						end
					end else if (!line_s.scl) begin
						timer <= 8'h00;
					end else if (half_done) begin
						drive_sda <= 1'b0;
						state <= i2css_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= i2css_pkg::ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* File: pkg/i2css_cfg.svh */
/*
 register offsets, control bit positions, status codes and timing counts
 of the slave state engine; included by bare name, no code of its own
*/
`ifndef I2CSS_CFG_SVH
`define I2CSS_CFG_SVH

`define I2CSS_OFS_CONTROL 8'h00
`define I2CSS_OFS_STATUS 8'h04
`define I2CSS_OFS_DATA 8'h08
`define I2CSS_OFS_OWNADR 8'h0C
`define I2CSS_OFS_IRQ_STAT 8'h10
`define I2CSS_OFS_IRQ_MASK 8'h14

`define I2CSS_CTL_AA 2
`define I2CSS_CTL_SI 3
`define I2CSS_CTL_STO 4
`define I2CSS_CTL_STA 5

`define I2CSS_IRQ_SI 0
`define I2CSS_IRQ_ARB 1

`define I2CSS_RST_OWNADR 8'h00
`define I2CSS_RST_MASK 2'h0

`define I2CSS_ST_IDLE 8'hF8
`define I2CSS_ST_MSTART 8'h08
`define I2CSS_ST_MW_ACK 8'h18
`define I2CSS_ST_MW_NACK 8'h20
`define I2CSS_ST_ARB 8'h38
`define I2CSS_ST_MR_ACK 8'h40
`define I2CSS_ST_MR_NACK 8'h48
`define I2CSS_ST_SW 8'h60
`define I2CSS_ST_SW_ARB 8'h68
`define I2CSS_ST_GC 8'h70
`define I2CSS_ST_GC_ARB 8'h78
`define I2CSS_ST_RX_ACK 8'h80
`define I2CSS_ST_RX_NACK 8'h88
`define I2CSS_ST_GRX_ACK 8'h90
`define I2CSS_ST_GRX_NACK 8'h98
`define I2CSS_ST_STOP 8'hA0
`define I2CSS_ST_SR 8'hA8
`define I2CSS_ST_SR_ARB 8'hB0
`define I2CSS_ST_TX_ACK 8'hB8
`define I2CSS_ST_TX_NACK 8'hC0
`define I2CSS_ST_TX_LAST 8'hC8

`define I2CSS_CLK_MHZ 25
`define I2CSS_HALF_NS 5000
`define I2CSS_HALF_CYC ((`I2CSS_HALF_NS * `I2CSS_CLK_MHZ + 999) / 1000)

`endif

/* File: pkg/i2css_pkg.sv */
/*
 types of the slave state engine: line pair and engine states
 assumes the cfg header carries all numbers
*/
package i2css_pkg;

	typedef struct packed {
		logic scl;
		logic sda;
	} i2css_line_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_AACK = 4'b0010,
		ST_RX = 4'b0011,
		ST_RACK = 4'b0100,
		ST_TX = 4'b0101,
		ST_TACK = 4'b0110,
		ST_HOLD = 4'b0111,
		ST_WFREE = 4'b1000,
		ST_MSTART = 4'b1001,
		ST_MBIT = 4'b1010,
		ST_MSTOP = 4'b1011
	} i2css_state_type;

endpackage

/* File: src/i2css_sync.sv */
/*
 three flip-flop synchroniser for the bus lines
 assumes asynchronous inputs; a change is taken once stages two and three agree
*/
`timescale 1ns/1ps
`default_nettype none

module i2css_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire i2css_pkg::i2css_line_type line_in,
	output var i2css_pkg::i2css_line_type line_out
);

	i2css_pkg::i2css_line_type s1;
	i2css_pkg::i2css_line_type s2;
	i2css_pkg::i2css_line_type s3;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 2'h3;
			s2 <= 2'h3;
			s3 <= 2'h3;
			line_out <= 2'h3;
		end else begin
			s1 <= line_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				line_out <= s3;
			end
		end
	end

endmodule

`default_nettype wire

/* File: testbench/i2css_checker_assertions.sv */
/*
 concurrent checks on the apb answer, the irq level and the line drivers
 assumes the ports of i2css_top; bound to it at the foot of this file
*/
`timescale 1ns/1ps
`default_nettype none

module i2css_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire i2css_pkg::i2css_line_type line_in,
	input wire i2css_pkg::i2css_line_type line_out,
	input wire i2css_pkg::i2css_line_type line_oe
);
	logic [1:0] mask_q;
	wire logic mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	wire logic mask_wr = psel && penable && pready && pwrite && paddr == 8'h14;

	// shadow of the irq mask, to tie irq to it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_q <= 2'h0;
		else if (mask_wr)
			mask_q <= pwdata[1:0];
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	ready_one_cycle_a: assert property (psel && !penable |=> pready)
		else $error("no ready in the first access cycle");
	ready_single_a: assert property (pready |=> !pready)
		else $error("ready stands longer than one cycle");
	unmapped_error_a: assert property (pready |-> pslverr == !mapped)
		else $error("slave error does not match the address map");
	error_data_a: assert property (pslverr |-> prdata == 32'h0000_0000)
		else $error("refused access returns data");
	idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside the answer cycle");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	open_drain_a: assert property (line_out == 2'h0)
		else $error("line driven high");
	irq_masked_a: assert property (irq |-> $past(mask_q) != 2'h0)
		else $error("irq raised while every source is masked");

	cover property (pslverr);
	cover property (irq);
	cover property (line_oe.scl && line_oe.sda);
endmodule

bind i2css_top i2css_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .line_in(line_in),
	.line_out(line_out), .line_oe(line_oe));

`default_nettype wire

/* File: testbench/i2css_master_model.sv */
/*
 behavioural i2c master: start, stop and byte transfers; scl low 320 ns, high 160 ns
 assumes open-drain lines resolved by the bench; waits while scl is stretched
*/
`timescale 1ns/1ps
`default_nettype none

module i2css_master_model (
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_oe,
	output logic sda_oe
);
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end

	// bounded wait while the slave holds scl low
	task automatic wait_high;
		int n;
		for (n = 0; n < 5000 && scl_w !== 1'b1; n++)
			#20;
	endtask

	// long low phase: the slave drives sda some six clocks after it sees scl fall,
	// and an sda change with scl high would read as a start or a stop
	task automatic bit_x(input logic b, output logic r);
		#80 sda_oe = !b;
		#240 scl_oe = 1'b0;
		wait_high();
		#160 r = sda_w;
		scl_oe = 1'b1;
	endtask

	task automatic start_c;
		sda_oe = 1'b1;
		#160 scl_oe = 1'b1;
	endtask

	task automatic stop_c;
		#80 sda_oe = 1'b1;
		#80 scl_oe = 1'b0;
		wait_high();
		#160 sda_oe = 1'b0;
		#320;
	endtask

	// eight bits msb first, then the acknowledge bit; scl left low
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic ao);
		int i;
		for (i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(ai, ao);
	endtask
endmodule

`default_nettype wire

/* File: testbench/i2c_slave_state_handling_tb.sv */
/*
 testbench of the slave state engine: apb tasks, master model, status checks
 assumes i2css_top with a short master half period
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2css_cfg.svh"

module i2c_slave_state_handling_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ak, err;
	logic [7:0] paddr, q;
	logic [31:0] pwdata, prdata, rq, k;
	i2css_pkg::i2css_line_type line_in, line_out, line_oe;
	wire logic m_scl_oe, m_sda_oe;
	int failures = 0;
	int check_count = 0;
	int cyc = 0;

	assign line_in.scl = !(line_oe.scl | m_scl_oe);
	assign line_in.sda = !(line_oe.sda | m_sda_oe);

	i2css_top #(.HALF_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.line_in(line_in), .line_out(line_out), .line_oe(line_oe));
	i2css_master_model bm (.scl_w(line_in.scl), .sda_w(line_in.sda), .scl_oe(m_scl_oe),
		.sda_oe(m_sda_oe));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = !pclk;
	end

	task print_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			print_verdict();
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rq = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50)
			chk(32'h0000_0000, 32'h0000_0001);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rq, e);
	endtask

	// wait for the interrupt, optionally clear its status bit
	task wsi(input logic clr);
		int n;
		for (n = 0; n < 3000 && irq !== 1'b1; n++)
			@(posedge pclk);
		chk(32'(irq), 32'h0000_0001);
		if (clr)
			wr(`I2CSS_OFS_IRQ_STAT, 32'h0000_0001);
	endtask

	task note(input string s);
		$display("test %s done at %0t", s, $time);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(`I2CSS_OFS_STATUS, 32'h0000_00F8);
		rd(`I2CSS_OFS_OWNADR, 32'h0000_0000);
		rd(`I2CSS_OFS_IRQ_MASK, 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk({rq[30:0], err}, 32'h0000_0001);
		wr(`I2CSS_OFS_STATUS, 32'h0000_0055);
		rd(`I2CSS_OFS_STATUS, 32'h0000_00F8);
		note("registers");
		wr(`I2CSS_OFS_OWNADR, 32'h0000_0055);
		wr(`I2CSS_OFS_IRQ_MASK, 32'h0000_0001);
		wr(`I2CSS_OFS_CONTROL, 32'h0000_0004);
		for (k = 0; k < 2; k++) begin
			bm.start_c();
			bm.xfer(8'h55, 1'b1, q, ak);
			chk(32'(ak), 32'h0000_0000);
			wsi(1'b1);
			rd(`I2CSS_OFS_STATUS, 32'h0000_00A8);
			wr(`I2CSS_OFS_DATA, 32'h0000_00A5 ^ k);
			wr(`I2CSS_OFS_CONTROL, 32'h0000_0008);
			bm.xfer(8'hFF, k[0], q, ak);
			chk(32'(q), 32'h0000_00A5 ^ k);
			wsi(1'b1);
			rd(`I2CSS_OFS_STATUS, k[0] ? 32'h0000_00C0 : 32'h0000_00C8);
			wr(`I2CSS_OFS_CONTROL, 32'h0000_000C);
			bm.xfer(8'hFF, 1'b1, q, ak);
			chk(32'(q), 32'h0000_00FF);
			bm.stop_c();
		end
		note("slave transmit");
		bm.start_c();
		bm.xfer(8'h00, 1'b1, q, ak);
		chk(32'(ak), 32'h0000_0000);
		wsi(1'b1);
		rd(`I2CSS_OFS_STATUS, 32'h0000_0070);
		wr(`I2CSS_OFS_CONTROL, 32'h0000_0008);
		bm.xfer(8'h3C, 1'b1, q, ak);
		chk(32'(ak), 32'h0000_0001);
		wsi(1'b1);
		rd(`I2CSS_OFS_STATUS, 32'h0000_0098);
		rd(`I2CSS_OFS_DATA, 32'h0000_003C);
		wr(`I2CSS_OFS_CONTROL, 32'h0000_0008);
		bm.stop_c();
		bm.start_c();
		bm.xfer(8'h54, 1'b1, q, ak);
		chk(32'(ak), 32'h0000_0001);
		bm.stop_c();
		wr(`I2CSS_OFS_CONTROL, 32'h0000_0004);
		wr(`I2CSS_OFS_OWNADR, 32'h0000_0054);
		bm.start_c();
		bm.xfer(8'h00, 1'b1, q, ak);
		chk(32'(ak), 32'h0000_0001);
		bm.stop_c();
		note("general call and ignore");
		bm.start_c();
		bm.xfer(8'h54, 1'b1, q, ak);
		chk(32'(ak), 32'h0000_0000);
		wsi(1'b1);
		rd(`I2CSS_OFS_STATUS, 32'h0000_0060);
		wr(`I2CSS_OFS_CONTROL, 32'h0000_000C);
		bm.xfer(8'h12, 1'b1, q, ak);
		wsi(1'b1);
		rd(`I2CSS_OFS_STATUS, 32'h0000_0080);
		rd(`I2CSS_OFS_DATA, 32'h0000_0012);
		wr(`I2CSS_OFS_CONTROL, 32'h0000_000C);
		bm.stop_c();
		wsi(1'b1);
		rd(`I2CSS_OFS_STATUS, 32'h0000_00A0);
		wr(`I2CSS_OFS_CONTROL, 32'h0000_002C);
		wsi(1'b0);
		rd(`I2CSS_OFS_STATUS, 32'h0000_0008);
		chk(32'(line_oe.scl), 32'h0000_0001);
		wr(`I2CSS_OFS_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0000_0000);
		wr(`I2CSS_OFS_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0000_0001);
		wr(`I2CSS_OFS_IRQ_STAT, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0000_0000);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`I2CSS_OFS_STATUS, 32'h0000_00F8);
		note("stop, start request and reset");
		print_verdict();
	end
endmodule

`default_nettype wire
